/* File: hdl/can_transceiver_ctl.sv */
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
// Contract
// RULE1: Mode select high or open means standby
// RULE2: Controller drives mode low for normal
// RULE3: Normal mode receive output follows bus
// RULE4: Normal mode transmit low drives dominant
// RULE5: Long dominant transmit disables the driver
// RULE6: Rising transmit edge ends time-out lock
// RULE7: Overtemperature disables the driver
// RULE8: After cooling, recessive edge releases driver
// RULE9: Standby turns off drivers and receiver
// RULE10: Filtered dominant in standby pulls output low
// RULE11: Filtered recessive afterwards returns output high
// RULE12: Standby entry while dominant gives no wake
// RULE13: Wake needs recessive then new dominant
// RULE14: Controller returns to normal on wake
// RULE15: Split termination on only in normal mode
// RULE16: Transmit input defaults to recessive
// RULE17: Bit rate keeps dominant runs under time-out
// RULE18: Time-out and filters are cycle parameters
`include "can_ctl_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Event FIFO, outputs decoded from pointer and storage flops, full and empty exact
module evt_fifo #(
  parameter int WIDTH = `EVT_W,
  parameter int DEPTH = `EVT_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  // Storage array
  logic [WIDTH-1:0] mem_ff [DEPTH];
  // Pointers carry one extra wrap bit
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic do_push;
  logic do_pop;

  assign do_push = in_valid_i && in_ready_o;
  assign do_pop = out_valid_o && out_ready_i;
  // Full when pointers differ only in the wrap bit
  assign in_ready_o = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                        (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
  assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
  assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];

  // Write side
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
    end else if (do_push) begin
      wr_ptr_ff <= wr_ptr_ff + 1'b1;
    end
  end

  // Storage has no reset; only valid words are ever read
  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
    end
  end

  // Read side
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ptr_ff <= '0;
    end else if (do_pop) begin
      rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule : evt_fifo

////////////////////////////////////////////////////////////////////////////////
// Transceiver control: mode, driver locks, wake filter, APB registers
module can_transceiver_ctl #(
  // RULE18: cycle count parameters
  // Dominant time-out in clock cycles
  parameter int TIMEOUT_CYC = 60000,
  // Wake dominant filter in clock cycles
  parameter int WAKE_DOM_CYC = 500,
  // Wake recessive filter in clock cycles
  parameter int WAKE_REC_CYC = 500
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic txd_i,
  input wire logic stb_i,
  input wire logic bus_dom_i,
  input wire logic overtemp_i,
  output logic bus_drive_o,
  output logic rxd_o,
  output logic split_en_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  // Counter step, cleared to zero when not running
  function automatic logic [`CNT_W-1:0] cnt_next(input logic [`CNT_W-1:0] c,
                                                  input logic run);
    cnt_next = run ? c + `CNT_ONE : '0;
  endfunction : cnt_next

  // Software standby request
  logic force_stb_ff;
  // Previous transmit level for edge detection
  logic txd_q_ff;
  // Locks on the driver
  logic to_lock_ff;
  logic ot_lock_ff;
  // Time-out counter and wake filter counter
  logic [`CNT_W-1:0] to_cnt_ff;
  logic [`CNT_W-1:0] filt_cnt_ff;
  logic [`CNT_W-1:0] nxt_filt_cnt;
  can_ctl_pkg::mode_type mode_ff;
  can_ctl_pkg::mode_type nxt_mode;
  // Output flops
  logic bus_drive_ff;
  logic rxd_ff;
  logic split_en_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  // Pending events waiting for FIFO room
  logic [`EVT_W-1:0] evt_pend_ff;
  logic [`EVT_W-1:0] evt_new;
  logic standby;
  logic txd_rise;
  logic to_hit;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`EVT_W-1:0] fifo_out_data;
  logic apb_done;
  logic evt_pop;

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode
  // RULE1: pin or software selects standby
  assign standby = stb_i || force_stb_ff;
  assign txd_rise = txd_i && !txd_q_ff;
  assign to_hit = (to_cnt_ff >= TIMEOUT_CYC[`CNT_W-1:0]);

  // Transmit edge history
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // RULE16: reset assumes recessive transmit
      txd_q_ff <= 1'b1;
    end else begin
      txd_q_ff <= txd_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dominant time-out
  // Counts consecutive dominant transmit cycles; stops at the limit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      to_cnt_ff <= '0;
    end else if (!to_hit || txd_i) begin
      to_cnt_ff <= cnt_next(to_cnt_ff, !txd_i);
    end
  end

  // Time-out lock
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      to_lock_ff <= 1'b0;
    end else if (to_hit && !txd_i) begin
      // RULE5: dominant too long locks driver
      to_lock_ff <= 1'b1;
    end else if (txd_rise) begin
      // RULE6: rising edge releases
      to_lock_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overtemperature lock; set wins while the condition stands
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ot_lock_ff <= 1'b0;
    end else if (overtemp_i) begin
      // RULE7: hot means driver off
      ot_lock_ff <= 1'b1;
    end else if (txd_rise) begin
      // RULE8: recessive edge after cooling
      ot_lock_ff <= 1'b0;
    end
  end

  // Bus driver output
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_drive_ff <= 1'b0;
    end else begin
      // RULE4: dominant while transmit low
      // RULE9: no drive in standby
      bus_drive_ff <= !standby && !txd_i && !to_lock_ff && !(to_hit && !txd_i) &&
                      !ot_lock_ff && !overtemp_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode and wake state machine
  always_comb begin
    nxt_mode = mode_ff;
    nxt_filt_cnt = '0;
    case (mode_ff)
      can_ctl_pkg::MODE_NORMAL: begin
        // RULE12: entering on a dominant bus blocks wake
        if (standby) begin
          nxt_mode = bus_dom_i ? can_ctl_pkg::MODE_STB_BLOCKED : can_ctl_pkg::MODE_STB_IDLE;
        end
      end
      can_ctl_pkg::MODE_STB_BLOCKED: begin
        // RULE13: wait for recessive bus first
        if (!standby) begin
          nxt_mode = can_ctl_pkg::MODE_NORMAL;
        end else if (!bus_dom_i) begin
          nxt_mode = can_ctl_pkg::MODE_STB_IDLE;
        end
      end
      can_ctl_pkg::MODE_STB_IDLE: begin
        nxt_filt_cnt = cnt_next(filt_cnt_ff, bus_dom_i);
        if (!standby) begin
          nxt_mode = can_ctl_pkg::MODE_NORMAL;
          nxt_filt_cnt = '0;
        end else if (bus_dom_i && filt_cnt_ff >= WAKE_DOM_CYC[`CNT_W-1:0]) begin
          // RULE10: filtered dominant wakes
          nxt_mode = can_ctl_pkg::MODE_STB_WOKE;
          nxt_filt_cnt = '0;
        end
      end
      can_ctl_pkg::MODE_STB_WOKE: begin
        nxt_filt_cnt = cnt_next(filt_cnt_ff, !bus_dom_i);
        if (!standby) begin
          nxt_mode = can_ctl_pkg::MODE_NORMAL;
          nxt_filt_cnt = '0;
        end else if (!bus_dom_i && filt_cnt_ff >= WAKE_REC_CYC[`CNT_W-1:0]) begin
          // RULE11: filtered recessive returns high
          nxt_mode = can_ctl_pkg::MODE_STB_IDLE;
          nxt_filt_cnt = '0;
        end
      end
      default: begin
        nxt_mode = can_ctl_pkg::MODE_STB_IDLE;
      end
    endcase
  end

  // State register; reset lands in standby since the pin defaults high
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_ff <= can_ctl_pkg::MODE_STB_IDLE;
      filt_cnt_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      filt_cnt_ff <= nxt_filt_cnt;
    end
  end

  // Receive output and split enable
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rxd_ff <= 1'b1;
      split_en_ff <= 1'b0;
    end else begin
      // RULE3: normal receive mirrors bus
      // RULE10: woke state shows low
      if (nxt_mode == can_ctl_pkg::MODE_NORMAL) begin
        rxd_ff <= !bus_dom_i;
      end else begin
        rxd_ff <= (nxt_mode != can_ctl_pkg::MODE_STB_WOKE);
      end
      // RULE15: split only in normal
      split_en_ff <= (nxt_mode == can_ctl_pkg::MODE_NORMAL);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event capture into the FIFO
  assign evt_new = {{(`EVT_W-3){1'b0}},
                    (mode_ff == can_ctl_pkg::MODE_STB_IDLE) &&
                      (nxt_mode == can_ctl_pkg::MODE_STB_WOKE),
                    overtemp_i && !ot_lock_ff,
                    to_hit && !txd_i && !to_lock_ff};

  // Events merge while the FIFO is full, so back-pressure keeps each event kind but not its count
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      evt_pend_ff <= '0;
    end else if (fifo_in_ready) begin
      evt_pend_ff <= evt_new;
    end else begin
      evt_pend_ff <= evt_pend_ff | evt_new;
    end
  end

  evt_fifo #(
    .WIDTH(`EVT_W),
    .DEPTH(`EVT_DEPTH)
  ) u_evt_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(|evt_pend_ff),
    .in_ready_o(fifo_in_ready),
    .in_data_i(evt_pend_ff),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(evt_pop),
    .out_data_o(fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state per access
  assign apb_done = psel_i && penable_i && pready_ff;
  assign evt_pop = apb_done && !pwrite_i && (paddr_i == `EVT_OFS);

  // Ready and answer data
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= psel_i && penable_i && !pready_ff;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
      if (psel_i && penable_i && !pready_ff) begin
        case (paddr_i)
          `CTL_OFS: begin
            prdata_ff[`CTL_FORCE_STB] <= force_stb_ff;
          end
          `STS_OFS: begin
            prdata_ff[`STS_STANDBY] <= (mode_ff != can_ctl_pkg::MODE_NORMAL);
            prdata_ff[`STS_TO_LOCK] <= to_lock_ff;
            prdata_ff[`STS_OT_LOCK] <= ot_lock_ff;
            prdata_ff[`STS_WOKE] <= (mode_ff == can_ctl_pkg::MODE_STB_WOKE);
            prdata_ff[`STS_EVT_VALID] <= fifo_out_valid;
            prdata_ff[`STS_EVT_FULL] <= !fifo_in_ready;
          end
          `EVT_OFS: begin
            // Empty FIFO reads as zero
            if (!pwrite_i && fifo_out_valid) begin
              prdata_ff[`EVT_W-1:0] <= fifo_out_data;
            end
          end
          default: begin
            // Unmapped address answers with an error
            pslverr_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  // Control register write
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      force_stb_ff <= `CTL_RST;
    end else if (apb_done && pwrite_i && paddr_i == `CTL_OFS) begin
      force_stb_ff <= pwdata_i[`CTL_FORCE_STB];
    end
  end

  assign bus_drive_o = bus_drive_ff;
  assign rxd_o = rxd_ff;
  assign split_en_o = split_en_ff;
  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
endmodule : can_transceiver_ctl

/* File: hdl/can_ctl_map.svh */
`ifndef CAN_CTL_MAP_SVH
`define CAN_CTL_MAP_SVH

// Register byte offsets
`define CTL_OFS 8'h00
`define STS_OFS 8'h04
`define EVT_OFS 8'h08
// Control fields
`define CTL_FORCE_STB 0
// Status fields
`define STS_STANDBY 0
`define STS_TO_LOCK 1
`define STS_OT_LOCK 2
`define STS_WOKE 3
`define STS_EVT_VALID 4
`define STS_EVT_FULL 5
// Event code bits
`define EVT_TO 0
`define EVT_OT 1
`define EVT_WAKE 2
// Sizes and reset values
`define EVT_W 8
`define EVT_DEPTH 16
`define CTL_RST 1'b0
`define CNT_W 32
`define CNT_ONE 32'h0000_0001

`endif

/* File: hdl/can_ctl_pkg.sv */
package can_ctl_pkg;
  // Operating state of the mode and wake logic
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STB_BLOCKED,
    MODE_STB_IDLE,
    MODE_STB_WOKE
  } mode_type;
endpackage : can_ctl_pkg

/* File: tb/can_transceiver_chk.sv */
`timescale 1ns/1ns
////////////////////////////////////////
// Pin and bus answer checks
module can_transceiver_chk #(
  parameter int TIMEOUT_CYC = 60000,
  // Wake runs below are fixed at 8, so filters must stay at 7 or under
  parameter int WAKE_DOM_CYC = 500,
  parameter int WAKE_REC_CYC = 500
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic txd_i,
  input wire logic stb_i,
  input wire logic bus_dom_i,
  input wire logic overtemp_i,
  input wire logic bus_drive_o,
  input wire logic rxd_o,
  input wire logic split_en_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o
);
  int lo_cnt_ff; // Transmit low run, saturating
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Low run counter, capped to avoid wrap
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lo_cnt_ff <= 0;
    end else if (txd_i) begin
      lo_cnt_ff <= 0;
    end else if (lo_cnt_ff < TIMEOUT_CYC + 8) begin
      lo_cnt_ff <= lo_cnt_ff + 1;
    end
  end
  // Locked by a long low run
  sequence s_locked;
    !txd_i && lo_cnt_ff >= TIMEOUT_CYC + 2;
  endsequence
  // Heat gone, transmit still low
  sequence s_cooled;
    $fell(overtemp_i) && !txd_i;
  endsequence
  // Recessive release pulse, then dominant again in normal mode
  sequence s_rearm;
    txd_i ##1 (!txd_i && !stb_i && !overtemp_i);
  endsequence
  // Standby with a dominant run longer than the wake filter
  sequence s_stb_dom8;
    (stb_i && bus_dom_i) [*8];
  endsequence
  // First access edge
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  ////////////////////////////////////////
  AST_STB_NO_DRIVE: assert property (stb_i |=> !bus_drive_o)
    else $error("drive active in standby");
  AST_STB_SPLIT: assert property (split_en_o |-> !$past(stb_i))
    else $error("split on in standby");
  AST_TX_NORMAL: assert property (bus_drive_o |-> !$past(txd_i))
    else $error("drive without low transmit");
  AST_RX_NORMAL: assert property (
    $past(split_en_o) && split_en_o |-> rxd_o == !$past(bus_dom_i))
    else $error("receive output not tracking bus");
  AST_OT_OFF: assert property (overtemp_i |=> !bus_drive_o)
    else $error("drive during overtemperature");
  AST_TO_LOCK: assert property (lo_cnt_ff > TIMEOUT_CYC + 1 |-> !bus_drive_o)
    else $error("drive after time-out");
  AST_TO_RELEASE: assert property (s_locked ##1 s_rearm |=> bus_drive_o)
    else $error("no release after rising transmit");
  AST_OT_HOLD: assert property (s_cooled ##1 (!txd_i) [*3] |-> !bus_drive_o)
    else $error("drive before recessive edge");
  AST_WAKE_LOW: assert property (stb_i && !bus_dom_i ##1 s_stb_dom8 |=> !rxd_o)
    else $error("no wake indication");
  AST_WAKE_HIGH: assert property ((stb_i && !bus_dom_i) [*8] |=> rxd_o)
    else $error("receive output not back high");
  AST_NO_FALSE_WAKE: assert property (!stb_i && bus_dom_i ##1 s_stb_dom8 |=> rxd_o)
    else $error("wake from stuck dominant");
  AST_APB_READY: assert property (s_access |=> pready_o ##1 !pready_o)
    else $error("ready not a one cycle answer");
endmodule : can_transceiver_chk

bind can_transceiver_ctl can_transceiver_chk #(
  .TIMEOUT_CYC(TIMEOUT_CYC), .WAKE_DOM_CYC(WAKE_DOM_CYC), .WAKE_REC_CYC(WAKE_REC_CYC)
) can_transceiver_chk_inst (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .txd_i(txd_i), .stb_i(stb_i),
  .bus_dom_i(bus_dom_i), .overtemp_i(overtemp_i), .bus_drive_o(bus_drive_o),
  .rxd_o(rxd_o), .split_en_o(split_en_o), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o)
);

/* File: tb/can_ctrl_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////
// Controller side: transmit and mode pins
module can_ctrl_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic tx_bit_i,
  input wire logic stb_req_i,
  input wire logic auto_wake_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic stb_o
);
  logic woke_ff; // Wake seen while watching
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      woke_ff <= 1'b0;
    end else begin
      woke_ff <= auto_wake_i && (woke_ff || !rxd_i);
    end
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      txd_o <= 1'b1;
      stb_o <= 1'b1;
    end else begin
      txd_o <= tx_bit_i;
      stb_o <= stb_req_i && !woke_ff;
    end
  end
endmodule : can_ctrl_model

/* File: tb/can_transceiver_ctl_tb.sv */
`timescale 1ns/1ns
module can_transceiver_ctl_tb;
  localparam int TO = 50; // Short time-out keeps the run brief
  localparam int WF = 5; // Short wake filters
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic txd_req = 1'b1;
  logic stb_req = 1'b1;
  logic auto_wake = 1'b0;
  logic bus_dom = 1'b0;
  logic overtemp = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic txd, stb, bus_drive, rxd, split_en, pready, pslverr, err;
  logic [31:0] prdata, rd;
  int mismatches = 0;
  int n_compared = 0;
  can_transceiver_ctl #(.TIMEOUT_CYC(TO), .WAKE_DOM_CYC(WF), .WAKE_REC_CYC(WF))
  can_transceiver_ctl_inst (.ref_clk_i(ref_clk), .rst_i(rst), .txd_i(txd), .stb_i(stb),
    .bus_dom_i(bus_dom), .overtemp_i(overtemp), .bus_drive_o(bus_drive), .rxd_o(rxd),
    .split_en_o(split_en), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr));
  can_ctrl_model can_ctrl_model_inst (.ref_clk_i(ref_clk), .rst_i(rst), .tx_bit_i(txd_req),
    .stb_req_i(stb_req), .auto_wake_i(auto_wake), .rxd_i(rxd), .txd_o(txd), .stb_o(stb));
  ////////////////////////////////////////
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task give_verdict;
    if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask : chk
  task chkb(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask : chkb
  task wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  // One transfer; answer taken at the rising edge that samples ready high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      give_verdict();
    end
    @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  ////////////////////////////////////////
  task t_regs;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctl reset", 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0);
    chkb("standby at reset", 1'b1, rd[0]);
    chkb("split at reset", 1'b0, split_en);
    apb(1'b0, 8'h0c, 32'h0);
    chkb("unmapped error", 1'b1, err);
    @(posedge ref_clk) stb_req <= 1'b0;
    wt(4);
    chkb("split normal", 1'b1, split_en);
    apb(1'b1, 8'h00, 32'h1);
    wt(2);
    chkb("split forced off", 1'b0, split_en);
    apb(1'b1, 8'h00, 32'h0);
    wt(2);
  endtask : t_regs
  task t_normal;
    @(posedge ref_clk) bus_dom <= 1'b1;
    wt(2);
    chkb("rxd dominant", 1'b0, rxd);
    @(posedge ref_clk) bus_dom <= 1'b0;
    txd_req <= 1'b0;
    wt(3);
    chkb("rxd recessive", 1'b1, rxd);
    chkb("drive dominant", 1'b1, bus_drive);
    @(posedge ref_clk) txd_req <= 1'b1;
    wt(3);
    chkb("drive recessive", 1'b0, bus_drive);
  endtask : t_normal
  task t_timeout;
    @(posedge ref_clk) txd_req <= 1'b0;
    wt(TO + 6);
    chkb("time-out drive", 1'b0, bus_drive);
    apb(1'b0, 8'h04, 32'h0);
    chkb("time-out status", 1'b1, rd[1]);
    wt(5);
    chkb("time-out held", 1'b0, bus_drive);
    @(posedge ref_clk) txd_req <= 1'b1;
    @(posedge ref_clk) txd_req <= 1'b0;
    wt(4);
    chkb("time-out released", 1'b1, bus_drive);
    @(posedge ref_clk) txd_req <= 1'b1;
  endtask : t_timeout
  task t_ot;
    @(posedge ref_clk) txd_req <= 1'b0;
    overtemp <= 1'b1;
    wt(4);
    chkb("hot drive", 1'b0, bus_drive);
    @(posedge ref_clk) overtemp <= 1'b0;
    wt(5);
    chkb("cooled held", 1'b0, bus_drive);
    apb(1'b0, 8'h04, 32'h0);
    chkb("ot lock status", 1'b1, rd[2]);
    @(posedge ref_clk) txd_req <= 1'b1;
    @(posedge ref_clk) txd_req <= 1'b0;
    wt(4);
    chkb("cooled released", 1'b1, bus_drive);
    @(posedge ref_clk) txd_req <= 1'b1;
  endtask : t_ot
  task t_wake;
    @(posedge ref_clk) bus_dom <= 1'b1;
    wt(2);
    @(posedge ref_clk) stb_req <= 1'b1;
    txd_req <= 1'b0;
    wt(14);
    chkb("no false wake", 1'b1, rxd);
    chkb("standby drive", 1'b0, bus_drive);
    chkb("standby split", 1'b0, split_en);
    @(posedge ref_clk) txd_req <= 1'b1;
    bus_dom <= 1'b0;
    wt(3);
    @(posedge ref_clk) bus_dom <= 1'b1;
    wt(WF + 4);
    chkb("wake low", 1'b0, rxd);
    apb(1'b0, 8'h04, 32'h0);
    chkb("woke status", 1'b1, rd[3]);
    @(posedge ref_clk) bus_dom <= 1'b0;
    wt(WF + 4);
    chkb("wake high", 1'b1, rxd);
  endtask : t_wake
  task t_auto;
    @(posedge ref_clk) auto_wake <= 1'b1;
    bus_dom <= 1'b1;
    wt(WF + 8);
    chkb("woken to normal", 1'b1, split_en);
    @(posedge ref_clk) bus_dom <= 1'b0;
    auto_wake <= 1'b0;
    stb_req <= 1'b0;
    wt(4);
  endtask : t_auto
  task t_fifo;
    int n;
    int hits;
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 40);
    // Each pulse needs a recessive edge after cooling to rearm the lock
    repeat (17) begin
      @(posedge ref_clk) overtemp <= 1'b1;
      txd_req <= 1'b0;
      @(posedge ref_clk) overtemp <= 1'b0;
      @(posedge ref_clk) txd_req <= 1'b1;
      @(posedge ref_clk);
    end
    apb(1'b0, 8'h04, 32'h0);
    chkb("events full", 1'b1, rd[5]);
    hits = 0;
    n = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      if (rd[1] === 1'b1) hits++;
      n++;
    end while (rd !== 32'h0 && n < 40);
    chk("overtemp events", 32'd17, hits);
    apb(1'b0, 8'h04, 32'h0);
    chkb("events empty", 1'b0, rd[4]);
  endtask : t_fifo
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_normal();
    t_timeout();
    t_ot();
    t_wake();
    t_auto();
    t_fifo();
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
endmodule : can_transceiver_ctl_tb
